/* logic/trf_formatter.sv */
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/10ps
module trf_formatter
	import trf_pkg::*;
(
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// conversion link
	input wire logic conv_clk_i,
	input wire logic conv_valid_i,
	input wire logic conv_chan_i,
	input wire logic [15:0] conv_temp_i,
	output logic conv_ready_o,
	// open-drain flags
	output logic alarm_n_o,
	output logic alarm_n_oe_o,
	output logic thermal_flag_n_o,
	output logic thermal_flag_n_oe_o
);

	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] loc_hi;
		logic [7:0] loc_lo;
		logic [7:0] rem_hi;
		logic [7:0] rem_lo;
		logic range;
		logic [1:0] res;
		logic [LIM_COUNT-1:0][7:0] lim;
		logic req_s1;
		logic req_s2;
		logic req_seen;
		logic [5:0] flags;
		logic alarm_oe;
		logic thermal_flag_n_oe;
		logic ack;
		logic [7:0] dat;
	} trf_main_s;

	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic req;
		logic ack_s1;
		logic ack_s2;
		logic chan;
		logic [15:0] temp;
	} trf_link_s;

	trf_main_s r;
	trf_main_s n;
	trf_link_s lr;
	trf_link_s ln;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// temperature is signed 12.4 fixed point; returns {high, low}
	function automatic logic [15:0] fmt_temp(input logic [15:0] t, input logic ext,
		input logic [3:0] mask);
		logic signed [12:0] ip;
		logic signed [12:0] sum;
		logic [7:0] frac;
		ip = 13'(signed'(t[15:4]));
		frac = {t[3:0] & mask, 4'h0};
		fmt_temp = {8'h00, frac};
		if (ext) begin
			sum = ip + EXT_OFFSET;
			if (sum < 0) begin
				fmt_temp = {MIN_CODE, 8'h00};
			end else if (sum > EXT_MAX_SUM) begin
				fmt_temp = {EXT_MAX_CODE, 8'h00};
			end else begin
				fmt_temp[15:8] = sum[7:0];
			end
		end else begin
			if (ip < 0) begin
				fmt_temp = {MIN_CODE, 8'h00};
			end else if (ip > STD_MAX_DEG) begin
				fmt_temp = {STD_MAX_CODE, 8'h00};
			end else begin
				fmt_temp[15:8] = ip[7:0];
			end
		end
	endfunction

	// local fraction mask from resolution code
	function automatic logic [3:0] res_mask(input logic [1:0] code);
		unique case (trf_res_e'(code))
			TRF_RES_HALF: res_mask = 4'h8;
			TRF_RES_QUARTER: res_mask = 4'hC;
			TRF_RES_EIGHTH: res_mask = 4'hE;
			TRF_RES_SIXTEENTH: res_mask = 4'hF;
		endcase
	endfunction

	// ------------------------------------------------------------
	// link domain: capture a conversion, hand it over by toggle
	// ------------------------------------------------------------
	logic link_idle;
	assign link_idle = (lr.req == lr.ack_s2) && !lr.rst_s2;
	assign conv_ready_o = link_idle;

	// word stays frozen until the toggle comes back, so it may cross unsynced
	always_comb begin
		ln = lr;
		ln.rst_s1 = rst_i;
		ln.rst_s2 = lr.rst_s1;
		ln.ack_s1 = r.req_seen;
		ln.ack_s2 = lr.ack_s1;
		if (lr.rst_s2) begin
			ln.req = 1'b0;
			ln.chan = 1'b0;
			ln.temp = 16'h0000;
		end else if (conv_valid_i && link_idle) begin
			ln.req = !lr.req;
			ln.chan = conv_chan_i;
			ln.temp = conv_temp_i;
		end
	end

	// link register bank
	always_ff @(posedge conv_clk_i) begin
		lr <= ln;
	end

	// ------------------------------------------------------------
	// main domain: format, store, compare, registers
	// ------------------------------------------------------------
	logic st_fire;
	logic st_rem;
	logic signed [11:0] st_int;
	logic [3:0] st_frac;
	logic [3:0] loc_mask;
	logic [15:0] st_code;
	logic wb_req;
	logic wb_wr;
	logic [5:0] cmp;

	assign st_fire = ce_i && (r.req_s2 != r.req_seen);
	assign st_rem = lr.chan;
	assign st_int = signed'(lr.temp[15:4]);
	assign st_frac = lr.temp[3:0];
	assign loc_mask = res_mask(r.res);
	// remote ignores the resolution setting
	assign st_code = fmt_temp(lr.temp, r.range, st_rem ? 4'hF : loc_mask);
	assign wb_req = cyc_i && stb_i && !r.ack;
	assign wb_wr = wb_req && we_i && sel_i[0];

	// per-channel comparisons on raw codes, no reformatting of limits
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_cmp
			logic [7:0] hi;
			assign hi = (ch == 0) ? r.loc_hi : r.rem_hi;
			assign cmp[2*ch] = hi > r.lim[2*ch];
			assign cmp[2*ch+1] = hi < r.lim[2*ch+1];
			assign cmp[4+ch] = hi > r.lim[LIM_LOC_THERMAL_FLAG_N+ch];
		end
	endgenerate

	// next state of the main bank
	always_comb begin
		n = r;
		n.req_s1 = lr.req;
		n.req_s2 = r.req_s1;
		n.ack = wb_req;
		n.flags = cmp;
		n.alarm_oe = |r.flags[3:0];
		n.thermal_flag_n_oe = |r.flags[5:4];
		// store uses the range in force when the conversion lands
		if (st_fire) begin
			n.req_seen = r.req_s2;
			if (st_rem) begin
				{n.rem_hi, n.rem_lo} = st_code;
			end else begin
				{n.loc_hi, n.loc_lo} = st_code;
			end
		end
		// register read
		if (wb_req) begin
			if (adr_i >= OFF_LIM_BASE && adr_i < OFF_STATUS) begin
				n.dat = r.lim[3'((adr_i - OFF_LIM_BASE) >> 2)];
			end else begin
				case ({adr_i[5:2], 2'b00})
					OFF_LOC_HI: n.dat = r.loc_hi;
					OFF_LOC_LO: n.dat = r.loc_lo;
					OFF_REM_HI: n.dat = r.rem_hi;
					OFF_REM_LO: n.dat = r.rem_lo;
					OFF_CONFIG: n.dat = 8'(r.range) << CFG_RANGE_BIT;
					OFF_RESOL: n.dat = {6'h00, r.res};
					OFF_STATUS: n.dat = {r.thermal_flag_n_oe, r.alarm_oe, r.flags};
					default: n.dat = 8'h00;
				endcase
			end
		end
		// register write; limits are stored as written, never converted
		if (wb_wr) begin
			if (adr_i >= OFF_LIM_BASE && adr_i < OFF_STATUS) begin
				n.lim[3'((adr_i - OFF_LIM_BASE) >> 2)] = dat_i[7:0];
			end else if ({adr_i[5:2], 2'b00} == OFF_CONFIG) begin
				n.range = dat_i[CFG_RANGE_BIT];
			end else if ({adr_i[5:2], 2'b00} == OFF_RESOL) begin
				n.res = dat_i[1:0];
			end
		end
		if (rst_i) begin
			n = '0;
			n.range = RANGE_RST;
			n.res = RES_RST;
			n.lim[LIM_LOC_HIGH] = LIM_HIGH_RST;
			n.lim[LIM_LOC_LOW] = LIM_LOW_RST;
			n.lim[LIM_REM_HIGH] = LIM_HIGH_RST;
			n.lim[LIM_REM_LOW] = LIM_LOW_RST;
			n.lim[LIM_LOC_THERMAL_FLAG_N] = LIM_THERMAL_FLAG_N_RST;
			n.lim[LIM_REM_THERMAL_FLAG_N] = LIM_THERMAL_FLAG_N_RST;
		end
	end

	// main register bank, frozen while ce_i is low unless rst_i is high
	always_ff @(posedge clk_i) begin
		if (rst_i || ce_i) begin
			r <= n;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// data level is always low: the pin is pulled low or released only
	assign alarm_n_o = 1'b0;
	assign thermal_flag_n_o = 1'b0;
	assign alarm_n_oe_o = r.alarm_oe;
	assign thermal_flag_n_oe_o = r.thermal_flag_n_oe;
	assign ack_o = r.ack;
	assign dat_o = {24'h000000, r.dat};

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_store_local;
		st_fire && !st_rem;
	endsequence

	sequence s_store_remote;
		st_fire && st_rem;
	endsequence

	sequence s_range_write;
		ce_i && wb_wr && ({adr_i[5:2], 2'b00} == OFF_CONFIG) && !st_fire;
	endsequence

	a_range_after_reset: assert property (@(posedge clk_i) disable iff (1'b0)
		$past(rst_i) |-> (r.range == 1'b0))
		else $error("range not standard after reset");

	a_keep_old_format: assert property (
		s_range_write |=> $stable(r.loc_hi) && $stable(r.rem_hi) && (r.range == $past(dat_i[CFG_RANGE_BIT])))
		else $error("range write disturbed stored results");

	a_std_clamp_low: assert property (
		s_store_local ##0 (!r.range && st_int < 0) |=> r.loc_hi == 8'h00)
		else $error("negative standard result not zero");

	a_std_clamp_high: assert property (
		s_store_remote ##0 (!r.range && st_int > 12'sd127) |=> r.rem_hi == 8'h7F)
		else $error("standard result not saturated at 7Fh");

	a_ext_offset_add: assert property (
		s_store_remote ##0 (r.range && st_int >= -12'sd64 && st_int <= 12'sd191)
		|=> r.rem_hi == $past(st_int[7:0]) + 8'h40)
		else $error("extended result lacks offset of 64");

	a_ext_saturate: assert property (
		s_store_local ##0 (r.range && st_int > 12'sd191) |=> r.loc_hi == 8'hFF)
		else $error("extended result not saturated at FFh");

	a_remote_sixteenth: assert property (
		s_store_remote ##0 (r.range && st_int >= 12'sd0 && st_int <= 12'sd100)
		|=> r.rem_lo == {$past(st_frac), 4'h0})
		else $error("remote fraction not full resolution");

	a_local_res_mask: assert property (
		s_store_local |=> (r.loc_lo[3:0] == 4'h0) && ((r.loc_lo[7:4] & ~$past(loc_mask)) == 4'h0))
		else $error("local fraction finer than selected resolution");

	a_alarm_follows: assert property (
		ce_i ##1 ce_i |-> alarm_n_oe_o == $past(|cmp[3:0], 2))
		else $error("alarm line does not follow limit compare");

	a_thermal_flag_n_follows: assert property (
		ce_i ##1 ce_i |-> thermal_flag_n_oe_o == $past(|cmp[5:4], 2))
		else $error("thermal flag does not follow thermal compare");

	a_never_drive_high: assert property (
		!alarm_n_o && !thermal_flag_n_o)
		else $error("flag line driven high");

	a_ack_one_cycle: assert property (
		ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

	a_link_word_hold: assert property (@(posedge conv_clk_i) disable iff (lr.rst_s2)
		(lr.req != lr.ack_s2) |=> $stable(lr.temp) && $stable(lr.chan))
		else $error("link word changed during handover");

endmodule

/* logic/trf_pkg.sv */
package trf_pkg;

	// ------------------------------------------------------------
	// register byte offsets on the wishbone slave
	// ------------------------------------------------------------
	localparam logic [5:0] OFF_LOC_HI = 6'h00;
	localparam logic [5:0] OFF_LOC_LO = 6'h04;
	localparam logic [5:0] OFF_REM_HI = 6'h08;
	localparam logic [5:0] OFF_REM_LO = 6'h0C;
	localparam logic [5:0] OFF_CONFIG = 6'h10;
	localparam logic [5:0] OFF_RESOL = 6'h14;
	localparam logic [5:0] OFF_LIM_BASE = 6'h18;
	localparam logic [5:0] OFF_STATUS = 6'h30;

	// ------------------------------------------------------------
	// limit slots, offset = base + 4 * slot
	// ------------------------------------------------------------
	localparam int LIM_LOC_HIGH = 0;
	localparam int LIM_LOC_LOW = 1;
	localparam int LIM_REM_HIGH = 2;
	localparam int LIM_REM_LOW = 3;
	localparam int LIM_LOC_THERMAL_FLAG_N = 4;
	localparam int LIM_REM_THERMAL_FLAG_N = 5;
	localparam int LIM_COUNT = 6;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CFG_RANGE_BIT = 2;
	localparam int STAT_ALARM_BIT = 6;
	localparam int STAT_THERMAL_FLAG_N_BIT = 7;

	// ------------------------------------------------------------
	// reset values and codes
	// ------------------------------------------------------------
	localparam logic RANGE_RST = 1'b0;
	localparam logic [1:0] RES_RST = 2'h0;
	localparam logic [7:0] LIM_HIGH_RST = 8'h55;
	localparam logic [7:0] LIM_LOW_RST = 8'h00;
	localparam logic [7:0] LIM_THERMAL_FLAG_N_RST = 8'h55;
	localparam logic [7:0] STD_MAX_CODE = 8'h7F;
	localparam logic [7:0] EXT_MAX_CODE = 8'hFF;
	localparam logic [7:0] MIN_CODE = 8'h00;
	localparam logic signed [12:0] EXT_OFFSET = 13'sh0040;
	localparam logic signed [12:0] STD_MAX_DEG = 13'sh007F;
	localparam logic signed [12:0] EXT_MAX_SUM = 13'sh00FF;

	// local resolution codes: half, quarter, eighth, sixteenth degree
	typedef enum logic [1:0] {
		TRF_RES_HALF = 2'b00,
		TRF_RES_QUARTER = 2'b01,
		TRF_RES_EIGHTH = 2'b10,
		TRF_RES_SIXTEENTH = 2'b11
	} trf_res_e;

endpackage

/* tb/trf_conv_src.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// conversion source: offers one result per request on the link
// ------------------------------------------------------------
module trf_conv_src (
	// link side
	input wire logic conv_clk_i,
	input wire logic conv_ready_i,
	output logic conv_valid_o = 1'b0,
	output logic conv_chan_o = 1'b0,
	output logic [15:0] conv_temp_o = 16'h0000,
	// bench side
	input wire logic go_i,
	input wire logic chan_i,
	input wire logic [15:0] temp_i,
	output logic acc_o = 1'b0
);
	// hold the offer until taken, then scramble the data it no longer owns
	always @(posedge conv_clk_i) begin
		if (conv_valid_o && conv_ready_i) begin
			conv_valid_o <= 1'b0;
			conv_temp_o <= ~conv_temp_o;
			conv_chan_o <= ~conv_chan_o;
			acc_o <= 1'b1;
		end else if (go_i && !acc_o && !conv_valid_o) begin
			conv_valid_o <= 1'b1;
			conv_chan_o <= chan_i;
			conv_temp_o <= temp_i;
		end else if (!go_i) begin
			acc_o <= 1'b0;
		end
	end
endmodule

/* tb/trf_formatter_tb.sv */
`timescale 1ns/10ps
module trf_formatter_tb;
	import trf_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic conv_clk = 1'b0, go = 1'b0, gch = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [31:0] wdat = 32'h00000000, dat_o, rd;
	logic [15:0] gtemp = 16'h0000, ctemp;
	logic ack_o, cvalid, cchan, cready, acc, al_n, al_oe, th_n, th_oe;
	int failures = 0, cmp_count = 0;
	// 100 MHz system clock, 64 ns link clock with unrelated phase
	initial forever #5 clk_i = ~clk_i;
	initial begin
		#7;
		forever #32 conv_clk = ~conv_clk;
	end
	trf_formatter dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .conv_clk_i(conv_clk),
		.conv_valid_i(cvalid), .conv_chan_i(cchan), .conv_temp_i(ctemp), .conv_ready_o(cready),
		.alarm_n_o(al_n), .alarm_n_oe_o(al_oe), .thermal_flag_n_o(th_n), .thermal_flag_n_oe_o(th_oe));
	trf_conv_src src (.conv_clk_i(conv_clk), .conv_ready_i(cready), .conv_valid_o(cvalid),
		.conv_chan_o(cchan), .conv_temp_o(ctemp), .go_i(go), .chan_i(gch), .temp_i(gtemp), .acc_o(acc));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic results();
		$display("compares %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// a spent bound is a hang: count it and close the run
	task automatic guard(input int n, input int lim);
		if (n >= lim) begin
			failures++;
			$display("BAD wait bound expected %0d seen %0d", lim - 1, n);
			results();
		end
	endtask
	// classic cycle: ack and data taken at the rising edge, request released right after it
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 40);
		guard(n, 40);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rdchk(input string nm, input logic [5:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(nm, e, rd[7:0]);
	endtask
	function automatic logic [5:0] lim(input int s);
		return OFF_LIM_BASE + 6'(4 * s);
	endfunction
	// one conversion in sixteenths of a degree; returns once the link is free again
	task automatic conv(input logic ch, input int s16);
		int n;
		n = 0;
		@(posedge clk_i);
		gch <= ch;
		gtemp <= s16[15:0];
		go <= 1'b1;
		do begin
			@(negedge clk_i);
			n++;
		end while (acc !== 1'b1 && n < 100);
		guard(n, 100);
		@(posedge clk_i);
		go <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (cready !== 1'b1 && n < 100);
		guard(n, 100);
		repeat (4) @(posedge clk_i);
	endtask
	task automatic flags(input logic [7:0] st, input logic a, input logic t);
		rdchk("status", OFF_STATUS, st);
		chk("alarm pull", {7'h00, a}, {7'h00, al_oe});
		chk("thermal pull", {7'h00, t}, {7'h00, th_oe});
		chk("line levels", 8'h00, {6'h00, al_n, th_n});
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rdchk("config", OFF_CONFIG, 8'h00);
		rdchk("resolution", OFF_RESOL, 8'h00);
		rdchk("loc high lim", lim(LIM_LOC_HIGH), LIM_HIGH_RST);
		rdchk("loc low lim", lim(LIM_LOC_LOW), LIM_LOW_RST);
		rdchk("rem thermal_flag_n lim", lim(LIM_REM_THERMAL_FLAG_N), LIM_THERMAL_FLAG_N_RST);
		wb(1'b1, OFF_LOC_HI, 8'h12);
		rdchk("read only", OFF_LOC_HI, 8'h00);
		rdchk("unmapped", 6'h34, 8'h00);
		flags(8'h00, 1'b0, 1'b0);
		$display("test reset done");
	endtask
	task automatic t_std();
		logic [3:0] m[4] = '{4'h8, 4'hC, 4'hE, 4'hF};
		conv(1'b0, -80);
		rdchk("below zero", OFF_LOC_HI, 8'h00);
		conv(1'b0, 200 * 16 + 5);
		rdchk("above 127", OFF_LOC_HI, STD_MAX_CODE);
		rdchk("clamped fraction", OFF_LOC_LO, 8'h00);
		for (int r = 0; r < 4; r++) begin
			wb(1'b1, OFF_RESOL, 8'(r));
			conv(1'b1, 25 * 16 + 11);
			rdchk("remote low", OFF_REM_LO, 8'hB0);
			rdchk("local kept", OFF_LOC_HI, r == 0 ? 8'h7F : 8'h19);
			conv(1'b0, 25 * 16 + 11);
			rdchk("local high", OFF_LOC_HI, 8'h19);
			rdchk("local low", OFF_LOC_LO, {4'hB & m[r], 4'h0});
		end
		conv(1'b1, 200 * 16 + 5);
		rdchk("remote above 127", OFF_REM_HI, STD_MAX_CODE);
		rdchk("remote clamped low", OFF_REM_LO, 8'h00);
		conv(1'b1, 25 * 16 + 11);
		$display("test standard done");
	endtask
	task automatic t_ext();
		int d[6] = '{0, -50, -70, 191, 200, -64};
		logic [7:0] hi[6] = '{8'h40, 8'h0E, 8'h00, 8'hFF, 8'hFF, 8'h00};
		logic [7:0] lo[6] = '{8'h30, 8'h30, 8'h00, 8'h30, 8'h00, 8'h30};
		wb(1'b1, OFF_CONFIG, 8'h04);
		rdchk("range bit", OFF_CONFIG, 8'h04);
		rdchk("stored format", OFF_LOC_HI, 8'h19);
		for (int i = 0; i < 6; i++) begin
			conv(1'b1, d[i] * 16 + 3);
			rdchk("ext high", OFF_REM_HI, hi[i]);
			rdchk("ext low", OFF_REM_LO, lo[i]);
		end
		conv(1'b0, 200 * 16 + 7);
		rdchk("ext local high", OFF_LOC_HI, EXT_MAX_CODE);
		rdchk("ext local low", OFF_LOC_LO, 8'h00);
		$display("test extended done");
	endtask
	task automatic t_lim();
		wb(1'b1, lim(LIM_LOC_HIGH), 8'h59);
		wb(1'b1, lim(LIM_LOC_THERMAL_FLAG_N), 8'h50);
		wb(1'b1, lim(LIM_LOC_LOW), 8'h45);
		flags(8'hD1, 1'b1, 1'b1);
		conv(1'b0, 30 * 16);
		flags(8'hD1, 1'b1, 1'b1);
		conv(1'b0, 20 * 16);
		flags(8'h90, 1'b0, 1'b1);
		conv(1'b0, 10 * 16);
		flags(8'h00, 1'b0, 1'b0);
		conv(1'b0, 0);
		flags(8'h42, 1'b1, 1'b0);
		$display("test limits done");
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_std();
		t_ext();
		t_lim();
		results();
	end
endmodule
